// [core/bpa_arbiter.sv]
`timescale 1ns/100ps
module bpa_arbiter #(
    parameter logic [bpa_pkg::WAIT_W-1:0] IDMA_MAX_WAIT = bpa_pkg::IDMA_WAIT_DEFAULT,
    parameter logic [bpa_pkg::WAIT_W-1:0] SDMA_MAX_WAIT = bpa_pkg::SDMA_WAIT_DEFAULT,
    parameter int EMC_DIV = bpa_pkg::CPU_CLKS_PER_EMC
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic [bpa_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [bpa_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // requestors, one lane per resource and requestor
    input wire logic [bpa_pkg::NUM_RES*bpa_pkg::NUM_REQ-1:0] req,
    input wire logic [bpa_pkg::NUM_RES*bpa_pkg::LVL_W-1:0] idma_pri,
    input wire logic [bpa_pkg::NUM_RES*bpa_pkg::LVL_W-1:0] sdma_pri,
    // grants
    output logic [bpa_pkg::NUM_RES*bpa_pkg::NUM_REQ-1:0] grant,
    output logic [bpa_pkg::NUM_RES-1:0] grant_boosted
);
    localparam int DIV_W = (EMC_DIV > 1) ? $clog2(EMC_DIV) : 1;
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(EMC_DIV - 1);
    localparam logic [DIV_W-1:0] DIV_ONE = DIV_W'(1);

    // external-memory tick
    logic [DIV_W-1:0] div_cnt;
    logic tick;

    // arbitration registers
    logic [31:0] cpu_arb [bpa_pkg::NUM_RES];
    logic [31:0] uc_arb [bpa_pkg::NUM_UC];

    // last grant per resource
    logic [bpa_pkg::IDX_W-1:0] last_idx [bpa_pkg::NUM_RES];
    logic [bpa_pkg::NUM_RES-1:0] last_boost;
    logic [bpa_pkg::NUM_RES-1:0] seen;
    logic [bpa_pkg::NUM_REQ-1:0] grant_q [bpa_pkg::NUM_RES];

    // bus state
    logic aw_held;
    logic w_held;
    logic [bpa_pkg::ADDR_W-1:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic commit;
    logic [31:0] status_word;
    logic [31:0] next_rdata;
    logic [1:0] next_rresp;
    logic [1:0] next_bresp;

    function automatic logic [31:0] bpa_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                              input logic [3:0] strb, input logic [31:0] mask);
        logic [31:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[8*b +: 8] = new_v[8*b +: 8];
            end
        end
        return res & mask;
    endfunction : bpa_merge

    // one arbitration cycle per external-memory clock
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_cnt <= '0;
        end else if (div_cnt == DIV_LAST) begin
            div_cnt <= '0;
        end else begin
            div_cnt <= div_cnt + DIV_ONE;
        end
    end

    assign tick = (div_cnt == DIV_LAST);

    // write channel acceptance, either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
        end else if (s_axi_awready && s_axi_awvalid) begin
            s_axi_awready <= 1'b0;
        end else if (!aw_held && !s_axi_bvalid) begin
            s_axi_awready <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_wready <= 1'b0;
        end else if (s_axi_wready && s_axi_wvalid) begin
            s_axi_wready <= 1'b0;
        end else if (!w_held && !s_axi_bvalid) begin
            s_axi_wready <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            aw_addr_q <= '0;
        end else if (s_axi_awready && s_axi_awvalid) begin
            aw_held <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
        end else if (commit) begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held <= 1'b0;
            w_data_q <= '0;
            w_strb_q <= '0;
        end else if (s_axi_wready && s_axi_wvalid) begin
            w_held <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
        end else if (commit) begin
            w_held <= 1'b0;
        end
    end

    assign commit = aw_held && w_held && !s_axi_bvalid;

    always_comb begin
        unique case ({aw_addr_q[bpa_pkg::ADDR_W-1:2], 2'b00})
            bpa_pkg::OFF_CPU_L1D, bpa_pkg::OFF_CPU_L2, bpa_pkg::OFF_CPU_EXT,
            bpa_pkg::OFF_UC_L1D, bpa_pkg::OFF_UC_L2, bpa_pkg::OFF_STATUS: begin
                next_bresp = bpa_pkg::RESP_OKAY;
            end
            default: begin
                next_bresp = bpa_pkg::RESP_SLVERR;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= bpa_pkg::RESP_OKAY;
        end else if (commit) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= next_bresp;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // register storage; status is read-only, writes to it are dropped
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int r = 0; r < bpa_pkg::NUM_RES; r++) begin
                cpu_arb[r] <= '0;
                cpu_arb[r][bpa_pkg::PRI_LSB +: bpa_pkg::PRI_W] <= bpa_pkg::CPU_PRI_RESET;
                cpu_arb[r][bpa_pkg::WAIT_LSB +: bpa_pkg::WAIT_W] <= bpa_pkg::CPU_WAIT_RESET;
            end
            for (int u = 0; u < bpa_pkg::NUM_UC; u++) begin
                uc_arb[u] <= '0;
                uc_arb[u][bpa_pkg::WAIT_LSB +: bpa_pkg::WAIT_W] <= bpa_pkg::UC_WAIT_RESET;
            end
        end else if (commit) begin
            unique case ({aw_addr_q[bpa_pkg::ADDR_W-1:2], 2'b00})
                bpa_pkg::OFF_CPU_L1D: begin
                    cpu_arb[bpa_pkg::RES_L1D] <= bpa_merge(cpu_arb[bpa_pkg::RES_L1D], w_data_q, w_strb_q,
                                                           bpa_pkg::CPU_ARB_WMASK);
                end
                bpa_pkg::OFF_CPU_L2: begin
                    cpu_arb[bpa_pkg::RES_L2] <= bpa_merge(cpu_arb[bpa_pkg::RES_L2], w_data_q, w_strb_q,
                                                          bpa_pkg::CPU_ARB_WMASK);
                end
                bpa_pkg::OFF_CPU_EXT: begin
                    cpu_arb[bpa_pkg::RES_EXT] <= bpa_merge(cpu_arb[bpa_pkg::RES_EXT], w_data_q, w_strb_q,
                                                           bpa_pkg::CPU_ARB_WMASK);
                end
                // no priority bits are kept in the coherence words
                bpa_pkg::OFF_UC_L1D: begin
                    uc_arb[bpa_pkg::RES_L1D] <= bpa_merge(uc_arb[bpa_pkg::RES_L1D], w_data_q, w_strb_q,
                                                          bpa_pkg::UC_ARB_WMASK);
                end
                bpa_pkg::OFF_UC_L2: begin
                    uc_arb[bpa_pkg::RES_L2] <= bpa_merge(uc_arb[bpa_pkg::RES_L2], w_data_q, w_strb_q,
                                                         bpa_pkg::UC_ARB_WMASK);
                end
                default: begin
                end
            endcase
        end
    end

    // read path
    always_comb begin
        status_word = '0;
        for (int r = 0; r < bpa_pkg::NUM_RES; r++) begin
            status_word[r*bpa_pkg::STAT_STRIDE +: bpa_pkg::IDX_W] = last_idx[r];
            status_word[r*bpa_pkg::STAT_STRIDE + bpa_pkg::STAT_BOOST_BIT] = last_boost[r];
            status_word[r*bpa_pkg::STAT_STRIDE + bpa_pkg::STAT_SEEN_BIT] = seen[r];
        end
    end

    always_comb begin
        next_rresp = bpa_pkg::RESP_OKAY;
        unique case ({s_axi_araddr[bpa_pkg::ADDR_W-1:2], 2'b00})
            bpa_pkg::OFF_CPU_L1D: next_rdata = cpu_arb[bpa_pkg::RES_L1D];
            bpa_pkg::OFF_CPU_L2: next_rdata = cpu_arb[bpa_pkg::RES_L2];
            bpa_pkg::OFF_CPU_EXT: next_rdata = cpu_arb[bpa_pkg::RES_EXT];
            bpa_pkg::OFF_UC_L1D: next_rdata = uc_arb[bpa_pkg::RES_L1D];
            bpa_pkg::OFF_UC_L2: next_rdata = uc_arb[bpa_pkg::RES_L2];
            bpa_pkg::OFF_STATUS: next_rdata = status_word;
            default: begin
                next_rdata = '0;
                next_rresp = bpa_pkg::RESP_SLVERR;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
        end else if (s_axi_arready && s_axi_arvalid) begin
            s_axi_arready <= 1'b0;
        end else if (!s_axi_rvalid) begin
            s_axi_arready <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= bpa_pkg::RESP_OKAY;
        end else if (s_axi_arready && s_axi_arvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rresp;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // per-resource arbitration
    for (genvar r = 0; r < bpa_pkg::NUM_RES; r++) begin : g_res
        logic [bpa_pkg::LVL_W-1:0] lvl [bpa_pkg::NUM_REQ];
        logic [bpa_pkg::NUM_REQ-1:0] boost;
        logic [bpa_pkg::NUM_REQ-1:0] live;
        logic [bpa_pkg::NUM_REQ-1:0] won;
        logic [bpa_pkg::WAIT_W-1:0] max_wait [bpa_pkg::NUM_REQ];
        logic [bpa_pkg::LVL_W-1:0] best_lvl;
        logic [bpa_pkg::IDX_W-1:0] best_idx;
        logic found;
        logic [bpa_pkg::PRI_W-1:0] cpu_pri;
        logic [bpa_pkg::LVL_W-1:0] idma_lvl;
        logic [bpa_pkg::LVL_W-1:0] sdma_lvl;
        logic [bpa_pkg::WAIT_W-1:0] uc_wait;

        // the external controller takes no user coherence requests
        if (r == bpa_pkg::RES_EXT) begin : g_no_uc
            assign uc_wait = bpa_pkg::WAIT_NONE;
            assign live = req[r*bpa_pkg::NUM_REQ +: bpa_pkg::NUM_REQ] &
                          ~(bpa_pkg::NUM_REQ'(1) << bpa_pkg::REQ_UC_GLOBAL) &
                          ~(bpa_pkg::NUM_REQ'(1) << bpa_pkg::REQ_UC_BLOCK);
        end else begin : g_uc
            assign uc_wait = uc_arb[r][bpa_pkg::WAIT_LSB +: bpa_pkg::WAIT_W];
            assign live = req[r*bpa_pkg::NUM_REQ +: bpa_pkg::NUM_REQ];
        end

        assign cpu_pri = cpu_arb[r][bpa_pkg::PRI_LSB +: bpa_pkg::PRI_W];
        // dma lanes may ask for level 8; anything beyond is clamped to it
        assign idma_lvl = ((idma_pri[r*bpa_pkg::LVL_W +: bpa_pkg::LVL_W] > bpa_pkg::LVL_MAX_PROG) ?
                           bpa_pkg::LVL_MAX_PROG : idma_pri[r*bpa_pkg::LVL_W +: bpa_pkg::LVL_W]) +
                          bpa_pkg::LVL_OFFSET;
        assign sdma_lvl = ((sdma_pri[r*bpa_pkg::LVL_W +: bpa_pkg::LVL_W] > bpa_pkg::LVL_MAX_PROG) ?
                           bpa_pkg::LVL_MAX_PROG : sdma_pri[r*bpa_pkg::LVL_W +: bpa_pkg::LVL_W]) +
                          bpa_pkg::LVL_OFFSET;

        // coherence raised by cpu or dma traffic arrives on that lane, with its settings
        assign max_wait[bpa_pkg::REQ_UC_GLOBAL] = bpa_pkg::WAIT_NONE;
        assign max_wait[bpa_pkg::REQ_CPU] = cpu_arb[r][bpa_pkg::WAIT_LSB +: bpa_pkg::WAIT_W];
        assign max_wait[bpa_pkg::REQ_IDMA] = IDMA_MAX_WAIT;
        assign max_wait[bpa_pkg::REQ_SDMA] = SDMA_MAX_WAIT;
        assign max_wait[bpa_pkg::REQ_UC_BLOCK] = uc_wait;

        assign lvl[bpa_pkg::REQ_UC_GLOBAL] = bpa_pkg::LVL_BOOST;
        assign lvl[bpa_pkg::REQ_CPU] = boost[bpa_pkg::REQ_CPU] ? bpa_pkg::LVL_BOOST :
                                       {1'b0, cpu_pri} + bpa_pkg::LVL_OFFSET;
        assign lvl[bpa_pkg::REQ_IDMA] = boost[bpa_pkg::REQ_IDMA] ? bpa_pkg::LVL_BOOST : idma_lvl;
        assign lvl[bpa_pkg::REQ_SDMA] = boost[bpa_pkg::REQ_SDMA] ? bpa_pkg::LVL_BOOST : sdma_lvl;
        assign lvl[bpa_pkg::REQ_UC_BLOCK] = boost[bpa_pkg::REQ_UC_BLOCK] ? bpa_pkg::LVL_BOOST :
                                            bpa_pkg::LVL_UC_BLOCK;

        // ties go to the lower lane index, so global coherence beats a boosted lane
        always_comb begin
            best_lvl = bpa_pkg::LVL_NONE;
            best_idx = '0;
            found = 1'b0;
            for (int q = 0; q < bpa_pkg::NUM_REQ; q++) begin
                if (live[q] && (!found || (lvl[q] < best_lvl))) begin
                    best_lvl = lvl[q];
                    best_idx = bpa_pkg::IDX_W'(q);
                    found = 1'b1;
                end
            end
        end

        for (genvar q = 0; q < bpa_pkg::NUM_REQ; q++) begin : g_req
            assign won[q] = tick && found && (best_idx == bpa_pkg::IDX_W'(q));

            bpa_wait_counter u_wait (
                .aclk(aclk),
                .aresetn(aresetn),
                .tick(tick),
                .req(live[q]),
                .won(won[q]),
                .max_wait(max_wait[q]),
                .boost(boost[q])
            );
        end

        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                grant_q[r] <= '0;
                grant_boosted[r] <= 1'b0;
            end else begin
                grant_q[r] <= won;
                grant_boosted[r] <= tick && found && boost[best_idx];
            end
        end

        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                last_idx[r] <= '0;
                last_boost[r] <= 1'b0;
                seen[r] <= 1'b0;
            end else if (tick && found) begin
                last_idx[r] <= best_idx;
                last_boost[r] <= boost[best_idx];
                seen[r] <= 1'b1;
            end
        end

        assign grant[r*bpa_pkg::NUM_REQ +: bpa_pkg::NUM_REQ] = grant_q[r];
    end
endmodule : bpa_arbiter

// [core/bpa_wait_counter.sv]
`timescale 1ns/100ps
module bpa_wait_counter (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // arbitration tick and request state
    input wire logic tick,
    input wire logic req,
    input wire logic won,
    input wire logic [bpa_pkg::WAIT_W-1:0] max_wait,
    // forced grant request
    output logic boost
);
    logic [bpa_pkg::WAIT_W-1:0] count;
    localparam logic [bpa_pkg::WAIT_W-1:0] CNT_ONE = 6'h01;
    localparam logic [bpa_pkg::WAIT_W-1:0] CNT_SAT = 6'h3F;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count <= '0;
        end else if (tick) begin
            // a withdrawn request also clears, so stale stall never carries over
            if (!req || won) begin
                count <= '0;
            end else if (count != CNT_SAT) begin
                count <= count + CNT_ONE;
            end
        end
    end

    // zero code never forces a grant
    assign boost = req && (max_wait != bpa_pkg::WAIT_NONE) && (count >= max_wait);
endmodule : bpa_wait_counter

// [dv/bpa_arbiter_asserts.sv]
`timescale 1ns/100ps
module bpa_arbiter_asserts (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // bus answers
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // arbitration
    input wire logic [bpa_pkg::NUM_RES*bpa_pkg::NUM_REQ-1:0] req,
    input wire logic [bpa_pkg::NUM_RES*bpa_pkg::NUM_REQ-1:0] grant,
    input wire logic [bpa_pkg::NUM_RES-1:0] grant_boosted
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    a_one_winner: assert property ($onehot0(grant[4:0]) && $onehot0(grant[9:5]) && $onehot0(grant[14:10]))
        else $error("two grants on one resource");
    a_grant_asked: assert property ((grant & ~($past(req) | $past(req, 2))) == 15'h0000)
        else $error("grant without request");
    a_ext_no_coherence: assert property (!grant[10] && !grant[14])
        else $error("coherence lane granted on external memory");
    a_tick_spacing: assert property (|grant[4:0] |=> grant[4:0] == 5'h00)
        else $error("grants closer than one tick");
    a_boost_granted: assert property (grant_boosted[0] |-> grant[4:0] != 5'h00)
        else $error("boost flag without grant");
    a_global_first: assert property (grant[4:0] != 5'h00 && $past(req[0]) && $past(req[0], 2) |-> grant[0])
        else $error("global coherence request lost");
    a_block_last: assert property (grant[4] && !grant_boosted[0]
        && $past(req[3:0]) == $past(req[3:0], 2) |-> $past(req[3:0]) == 4'h0)
        else $error("block coherence beat a live request");
    a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
endmodule : bpa_arbiter_asserts

bind bpa_arbiter bpa_arbiter_asserts i_chk (.aclk, .aresetn, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .req, .grant, .grant_boosted);

// [dv/bpa_req_model.sv]
`timescale 1ns/100ps
module bpa_req_model (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // wanted lanes, count clear, answers
    input wire logic [14:0] want,
    input wire logic clr,
    input wire logic [14:0] grant,
    // requests
    output logic [14:0] req
);
    int unsigned gcnt [15];
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            req <= 15'h0000;
        end else begin
            req <= want; // lanes re-ask at once, so contention never lets up
        end
    end
    always_ff @(posedge aclk) begin
        for (int k = 0; k < 15; k++) begin
            gcnt[k] <= clr ? 0 : gcnt[k] + int'(grant[k]);
        end
    end
endmodule : bpa_req_model

// [dv/tb.sv]
`timescale 1ns/100ps
module tb;
    logic aclk, aresetn, clr, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [14:0] req, grant, want;
    logic [11:0] idma_pri, sdma_pri;
    logic [2:0] grant_boosted;
    int err_count = 0;
    int cmp_count = 0;
    bpa_arbiter i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .req, .idma_pri, .sdma_pri,
        .grant, .grant_boosted);
    bpa_req_model i_req (.aclk, .aresetn, .want, .clr, .grant, .req);
    task automatic tally_and_finish();
        if (err_count == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : tally_and_finish
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            err_count++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask : chk
    task automatic chk_rng(input string n, input int lo, input int hi, input int g);
        cmp_count++;
        if (g < lo || g > hi) begin
            err_count++;
            $display("BAD %s exp %0d..%0d got %0d", n, lo, hi, g);
        end
    endtask : chk_rng
    // ready is looked at on the falling edge, where it already shows what the next rising edge samples
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic ha, hw;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(negedge aclk);
            ha = s_axi_awvalid && s_axi_awready;
            hw = s_axi_wvalid && s_axi_wready;
            @(posedge aclk);
            if (ha) s_axi_awvalid <= 1'b0;
            if (hw) s_axi_wvalid <= 1'b0;
        end while (s_axi_awvalid || s_axi_wvalid);
        do @(negedge aclk); while (!s_axi_bvalid);
        @(posedge aclk);
        s_axi_bready <= 1'b1;
        @(negedge aclk);
        chk("bresp", 32'(er), 32'(s_axi_bresp));
        @(posedge aclk);
        s_axi_bready <= 1'b0;
    endtask : axi_wr
    task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(negedge aclk); while (!s_axi_arready);
        @(posedge aclk);
        s_axi_arvalid <= 1'b0;
        do @(negedge aclk); while (!s_axi_rvalid);
        @(posedge aclk);
        s_axi_rready <= 1'b1;
        @(negedge aclk);
        chk("rdata", ed, s_axi_rdata);
        chk("rresp", 32'(er), 32'(s_axi_rresp));
        @(posedge aclk);
        s_axi_rready <= 1'b0;
    endtask : axi_rd
    task automatic run(input logic [14:0] w, input int n);
        @(posedge aclk);
        clr <= 1'b1;
        want <= w;
        @(posedge aclk);
        clr <= 1'b0;
        repeat (n) @(posedge aclk);
        want <= 15'h0000;
        repeat (6) @(posedge aclk);
    endtask : run
    task automatic t_reset();
        axi_rd(8'h00, 32'h0001_0010, 2'h0);
        axi_rd(8'h04, 32'h0001_0010, 2'h0);
        axi_rd(8'h08, 32'h0001_0010, 2'h0);
        axi_rd(8'h0C, 32'h0000_0020, 2'h0);
        axi_rd(8'h10, 32'h0000_0020, 2'h0);
        axi_rd(8'h18, 32'h0000_0000, 2'h2);
        s_axi_wstrb <= 4'h4;
        axi_wr(8'h00, 32'hFFFF_FFFF, 2'h0);
        axi_rd(8'h00, 32'h0007_0010, 2'h0);
        s_axi_wstrb <= 4'hF;
        axi_wr(8'h04, 32'hFFFF_FFFF, 2'h0);
        axi_rd(8'h04, 32'h0007_003F, 2'h0);
        axi_wr(8'h10, 32'hFFFF_FFFF, 2'h0);
        axi_rd(8'h10, 32'h0000_003F, 2'h0);
    endtask : t_reset
    // windows stay under 16 ticks so the dma lane's own wait never fires
    task automatic t_prio();
        axi_wr(8'h04, 32'h0003_0000, 2'h0);
        idma_pri <= 12'h020;
        run(15'h00C0, 28);
        chk_rng("l2 cpu wait zero", 0, 0, i_req.gcnt[6]);
        chk_rng("l2 idma higher", 12, 15, i_req.gcnt[7]);
        axi_wr(8'h04, 32'h0007_0000, 2'h0);
        idma_pri <= 12'h0F0;
        run(15'h00C0, 28);
        chk_rng("l2 cpu level 7", 12, 15, i_req.gcnt[6]);
        chk_rng("l2 idma clamped", 0, 0, i_req.gcnt[7]);
        axi_rd(8'h14, 32'h0000_1100, 2'h0);
    endtask : t_prio
    task automatic t_wait();
        for (int i = 0; i < 6; i++) begin
            axi_wr(8'h00, 32'h0007_0000 | (32'h1 << i), 2'h0);
            run(15'h0006, 200);
            chk_rng("l1d cpu share", 100 / ((1 << i) + 1) - 2, 100 / ((1 << i) + 1) + 2, i_req.gcnt[1]);
            chk_rng("l1d grants per tick", 98, 102, i_req.gcnt[1] + i_req.gcnt[2]);
        end
    endtask : t_wait
    task automatic t_coh();
        axi_wr(8'h00, 32'h0007_0001, 2'h0);
        axi_wr(8'h0C, 32'h0000_0001, 2'h0);
        run(15'h7C1F, 40);
        chk_rng("global wins", 18, 22, i_req.gcnt[0]);
        chk_rng("boosted cpu behind global", 0, 0, i_req.gcnt[1]);
        chk_rng("block wait vs global", 0, 0, i_req.gcnt[4]);
        chk_rng("ext global lane", 0, 0, i_req.gcnt[10]);
        chk_rng("ext block lane", 0, 0, i_req.gcnt[14]);
        axi_wr(8'h00, 32'h0000_0000, 2'h0);
        axi_wr(8'h0C, 32'h0000_0000, 2'h0);
        run(15'h0012, 40);
        chk_rng("block lowest", 0, 0, i_req.gcnt[4]);
        run(15'h0010, 10);
        chk_rng("block alone wins", 4, 6, i_req.gcnt[4]);
        axi_wr(8'h0C, 32'h0000_0002, 2'h0);
        run(15'h0012, 60);
        chk_rng("block one in three", 8, 12, i_req.gcnt[4]);
    endtask : t_coh
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, clr, want} = 21'h00_0000;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0000_0000_0000;
        s_axi_wstrb = 4'hF;
        idma_pri = 12'h000;
        sdma_pri = 12'h777;
        aresetn = 1'b0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        t_reset();
        t_prio();
        t_wait();
        t_coh();
        tally_and_finish();
    end
    initial begin
        repeat (8000) @(posedge aclk);
        err_count++;
        tally_and_finish();
    end
endmodule : tb

// [inc/bpa_pkg.sv]
// Operation
// - cpu arbitration word holds 3-bit priority in bits 18:16, 0 highest, 7 lowest
// - programmed levels order requests; level 8 exists for dma lanes, not cpu field
// - cpu arbitration word holds 6-bit maximum wait in bits 5:0
// - stall cycles counted on external-memory ticks, one tick per two cpu clocks
// - maximum wait zero: never force a grant, stall while higher levels contend
// - wait n gives one access per n+1 arbitration cycles under contention
// - user coherence setting governs user writeback and invalidate commands
// - global user coherence requests always win as top level
// - block user coherence requests rank below every other request until their wait boosts them
// - user coherence word has no priority field, priorities are fixed
// - user coherence wait applies to block operations only, global ignores it
// - user coherence words exist for level-1 data and level-2 only
// - coherence caused by cpu or dma uses the causing lane's settings
// - per-request contention counter counts blocked ticks, clears when granted
// - counter at maximum wait boosts request to level 0 for a grant
// - among contenders the lowest numeric level is granted
package bpa_pkg;
    localparam int NUM_RES = 3;
    localparam int NUM_REQ = 5;
    localparam int NUM_UC = 2;
    localparam int RES_L1D = 0;
    localparam int RES_L2 = 1;
    localparam int RES_EXT = 2;
    localparam int REQ_UC_GLOBAL = 0;
    localparam int REQ_CPU = 1;
    localparam int REQ_IDMA = 2;
    localparam int REQ_SDMA = 3;
    localparam int REQ_UC_BLOCK = 4;
    localparam int IDX_W = 3;
    localparam int LVL_W = 4;
    localparam logic [LVL_W-1:0] LVL_BOOST = 4'h0;
    localparam logic [LVL_W-1:0] LVL_OFFSET = 4'h1;
    localparam logic [LVL_W-1:0] LVL_MAX_PROG = 4'h8;
    localparam logic [LVL_W-1:0] LVL_UC_BLOCK = 4'hA;
    localparam logic [LVL_W-1:0] LVL_NONE = 4'hF;
    localparam int PRI_LSB = 16;
    localparam int PRI_W = 3;
    localparam int WAIT_LSB = 0;
    localparam int WAIT_W = 6;
    localparam logic [31:0] CPU_ARB_WMASK = 32'h0007_003F;
    localparam logic [31:0] UC_ARB_WMASK = 32'h0000_003F;
    localparam logic [PRI_W-1:0] CPU_PRI_RESET = 3'h1;
    localparam logic [WAIT_W-1:0] CPU_WAIT_RESET = 6'h10;
    localparam logic [WAIT_W-1:0] UC_WAIT_RESET = 6'h20;
    localparam logic [WAIT_W-1:0] IDMA_WAIT_DEFAULT = 6'h10;
    localparam logic [WAIT_W-1:0] SDMA_WAIT_DEFAULT = 6'h01;
    localparam logic [WAIT_W-1:0] WAIT_NONE = 6'h00;
    localparam int CPU_CLKS_PER_EMC = 2;
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] OFF_CPU_L1D = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_CPU_L2 = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_CPU_EXT = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_UC_L1D = 8'h0C;
    localparam logic [ADDR_W-1:0] OFF_UC_L2 = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h14;
    localparam int STAT_STRIDE = 8;
    localparam int STAT_BOOST_BIT = 3;
    localparam int STAT_SEEN_BIT = 4;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : bpa_pkg
